/* File: logic/dac_irq_sources.sv */
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module dac_irq_sources
   import dac_irq_pkg::*;
#(
   parameter int NF = 32,
   parameter int NG = 8,
   parameter int FW = 16,
   parameter int TW = 16
) (
   // clock and reset
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   // axi4-lite write address
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
   // axi4-lite write data
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   input  wire logic [DATA_W-1:0]             s_axi_wdata,
   input  wire logic [STRB_W-1:0]             s_axi_wstrb,
   // axi4-lite write response
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   output logic [1:0]                         s_axi_bresp,
   // axi4-lite read address
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   input  wire logic [ADDR_W-1:0]             s_axi_araddr,
   // axi4-lite read data
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   output logic [DATA_W-1:0]                  s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   // fifo fill levels and limits
   input  wire logic [NF-1:0][FW-1:0]         fifo_fill,
   input  wire logic [NF-1:0][FW-1:0]         fifo_limit,
   // quad-DAC group events
   input  wire qdac_event_type [NG-1:0]       group_evt,
   // interrupt flags, status read requests and group control words
   output logic                               fifo_level_irq,
   output logic [NG-1:0]                      sequencer_request_irq,
   output logic [NG-1:0]                      output_load_irq,
   output logic [NG-1:0]                      overcurrent_thermal_irq,
   output logic [NG-1:0]                      status_read_req,
   output group_ctrl_type [NG-1:0]            group_ctrl
);

   localparam int SEQ_BASE   = 0;
   localparam int LOAD_BASE  = NG;
   localparam int ALERT_BASE = 2 * NG;

   typedef struct packed {
      logic [NF-1:0]           fifo_en;
      logic [NF-1:0]           fifo_low;
      logic                    fifo_irq;
      logic [NG-1:0]           seq_irq;
      logic [NG-1:0]           load_irq;
      logic [NG-1:0]           alert_irq;
      logic [NG-1:0]           stat_req;
      group_ctrl_type [NG-1:0] ctrl;
      logic [TW-1:0]           period;
      logic [TW-1:0]           tcount;
      logic                    aw_got;
      logic                    w_got;
      logic [ADDR_W-1:0]       awaddr;
      logic [DATA_W-1:0]       wdata;
      logic [STRB_W-1:0]       wstrb;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    rvalid;
      logic [DATA_W-1:0]       rdata;
      logic [1:0]              rresp;
   } state_type;

   state_type     s_q;
   state_type     s_d;
   logic [NF-1:0] fifo_below;

   function automatic reg_sel_type decode(input logic [ADDR_W-1:0] a);
      reg_sel_type sel;
      sel = SEL_NONE;
      if (a == OFS_FIFO_EN) sel = SEL_FIFO_EN;
      else if (a == OFS_FIFO_STAT) sel = SEL_FIFO_STAT;
      else if (a == OFS_GRP_STAT) sel = SEL_GRP_STAT;
      else if (a == OFS_TIMER) sel = SEL_TIMER;
      else if (a == OFS_SUMMARY) sel = SEL_SUMMARY;
      else begin
         for (int g = 0; g < NG; g++) begin
            if (a == OFS_GRP_CTRL + ADDR_W'(g * GRP_STRIDE)) sel = SEL_GRP_CTRL;
         end
      end
      return sel;
   endfunction

   function automatic logic [DATA_W-1:0] lane_mask(input logic [STRB_W-1:0] strb);
      logic [DATA_W-1:0] m;
      m = '0;
      for (int b = 0; b < STRB_W; b++) begin
         m[b*8 +: 8] = {8{strb[b]}};
      end
      return m;
   endfunction

   // empty counts as low even when the limit is zero
   for (genvar i = 0; i < NF; i++) begin : g_fifo_cmp
      assign fifo_below[i] = (fifo_fill[i] < fifo_limit[i]) || (fifo_fill[i] == '0);
   end

   always_comb begin
      logic                aw_take;
      logic                w_take;
      logic                do_wr;
      logic [ADDR_W-1:0]   wa;
      logic [DATA_W-1:0]   wd;
      logic [DATA_W-1:0]   wm;
      logic [DATA_W-1:0]   clr;
      logic [DATA_W-1:0]   rd;
      logic                expire;
      reg_sel_type         wsel;
      reg_sel_type         rsel;
      qdac_event_type      ev;
      group_ctrl_type      c;
      aw_take = 1'b0;
      w_take  = 1'b0;
      do_wr   = 1'b0;
      wa      = '0;
      wd      = '0;
      wm      = '0;
      clr     = '0;
      rd      = '0;
      expire  = 1'b0;
      wsel    = SEL_NONE;
      rsel    = SEL_NONE;
      ev      = '0;
      c       = GRP_CTRL_RESET;
      s_d     = s_q;

      // write channels, taken in either order
      aw_take = s_axi_awvalid && s_axi_awready;
      w_take  = s_axi_wvalid && s_axi_wready;
      if (aw_take) begin
         s_d.aw_got = 1'b1;
         s_d.awaddr = s_axi_awaddr;
      end
      if (w_take) begin
         s_d.w_got = 1'b1;
         s_d.wdata = s_axi_wdata;
         s_d.wstrb = s_axi_wstrb;
      end
      if (s_q.bvalid && s_axi_bready) s_d.bvalid = 1'b0;
      do_wr = s_d.aw_got && s_d.w_got;
      wa    = s_d.awaddr;
      wd    = s_d.wdata;
      wm    = lane_mask(s_d.wstrb);
      wsel  = decode(wa);
      if (do_wr) begin
         s_d.aw_got = 1'b0;
         s_d.w_got  = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp  = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         case (wsel)
            SEL_FIFO_EN: s_d.fifo_en = NF'((DATA_W'(s_q.fifo_en) & ~wm) | (wd & wm));
            SEL_TIMER:   s_d.period  = TW'((DATA_W'(s_q.period) & ~wm) | (wd & wm));
            SEL_GRP_STAT: clr = wd & wm;
            SEL_GRP_CTRL: begin
               for (int g = 0; g < NG; g++) begin
                  if (wa == OFS_GRP_CTRL + ADDR_W'(g * GRP_STRIDE)) begin
                     s_d.ctrl[g] = group_ctrl_type'(GRP_CTRL_W'((DATA_W'(s_q.ctrl[g]) & ~wm) | (wd & wm)));
                  end
               end
            end
            default: ;
         endcase
      end

      // fifo aggregation, level driven so it clears without acknowledge
      s_d.fifo_low = fifo_below & s_q.fifo_en;
      s_d.fifo_irq = |(fifo_below & s_q.fifo_en);

      // cyclic auto status timer, period zero stops it
      if (s_q.period == '0) begin
         s_d.tcount = '0;
      end else if (s_q.tcount >= TW'(s_q.period - TW'(1))) begin
         expire     = 1'b1;
         s_d.tcount = '0;
      end else begin
         s_d.tcount = TW'(s_q.tcount + TW'(1));
      end

      // per-group flags, set wins over a same-cycle clear
      for (int g = 0; g < NG; g++) begin
         ev = group_evt[g];
         c  = s_q.ctrl[g];
         s_d.seq_irq[g] = (s_q.seq_irq[g] && !clr[SEQ_BASE + g])
                          || (ev.seq_request && c.seq_en);
         s_d.load_irq[g] = (s_q.load_irq[g] && !clr[LOAD_BASE + g])
                           || (ev.load_done && c.load_en && c.mode == MODE_MEMORY);
         s_d.alert_irq[g] = (s_q.alert_irq[g] && !clr[ALERT_BASE + g])
                            || (ev.status_valid && c.alert_en
                                && ((|ev.overcurrent) || ev.thermal_alert));
         case (c.mode)
            MODE_IMMEDIATE, MODE_MEMORY: s_d.stat_req[g] = c.auto_status_en && expire;
            MODE_FIFO, MODE_SEQUENCE:    s_d.stat_req[g] = c.auto_status_en && ev.seq_request;
            default:                     s_d.stat_req[g] = 1'b0;
         endcase
      end

      // read channel
      if (s_q.rvalid && s_axi_rready) s_d.rvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
         rsel = decode(s_axi_araddr);
         case (rsel)
            SEL_FIFO_EN:   rd = DATA_W'(s_q.fifo_en);
            SEL_FIFO_STAT: rd = DATA_W'(s_q.fifo_low);
            SEL_GRP_STAT: begin
               rd[SEQ_BASE   +: NG] = s_q.seq_irq;
               rd[LOAD_BASE  +: NG] = s_q.load_irq;
               rd[ALERT_BASE +: NG] = s_q.alert_irq;
            end
            SEL_TIMER:     rd = DATA_W'(s_q.period);
            SEL_SUMMARY: begin
               rd[SUM_FIFO_BIT]  = s_q.fifo_irq;
               rd[SUM_SEQ_BIT]   = |s_q.seq_irq;
               rd[SUM_LOAD_BIT]  = |s_q.load_irq;
               rd[SUM_ALERT_BIT] = |s_q.alert_irq;
            end
            SEL_GRP_CTRL: begin
               for (int g = 0; g < NG; g++) begin
                  if (s_axi_araddr == OFS_GRP_CTRL + ADDR_W'(g * GRP_STRIDE)) rd = DATA_W'(s_q.ctrl[g]);
               end
            end
            default:       rd = '0;
         endcase
         s_d.rvalid = 1'b1;
         s_d.rdata  = rd;
         s_d.rresp  = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q        <= '0;
         s_q.period <= TW'(TIMER_RESET);
         for (int g = 0; g < NG; g++) begin
            s_q.ctrl[g] <= GRP_CTRL_RESET;
         end
      end else begin
         s_q <= s_d;
      end
   end

   // one write and one read in flight; ready drops while the answer waits
   assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
   assign s_axi_wready  = !s_q.w_got && !s_q.bvalid;
   assign s_axi_arready = !s_q.rvalid;
   assign s_axi_bvalid  = s_q.bvalid;
   assign s_axi_bresp   = s_q.bresp;
   assign s_axi_rvalid  = s_q.rvalid;
   assign s_axi_rdata   = s_q.rdata;
   assign s_axi_rresp   = s_q.rresp;

   assign fifo_level_irq          = s_q.fifo_irq;
   assign sequencer_request_irq   = s_q.seq_irq;
   assign output_load_irq         = s_q.load_irq;
   assign overcurrent_thermal_irq = s_q.alert_irq;
   assign status_read_req         = s_q.stat_req;
   assign group_ctrl              = s_q.ctrl;

endmodule // dac_irq_sources

/* File: logic/dac_irq_pkg.sv */
package dac_irq_pkg;

   // register bus geometry
   localparam int ADDR_W      = 8;
   localparam int DATA_W      = 32;
   localparam int STRB_W      = DATA_W / 8;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_FIFO_EN   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_FIFO_STAT = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_GRP_STAT  = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_TIMER     = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_SUMMARY   = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_GRP_CTRL  = 8'h20;
   localparam int                GRP_STRIDE    = 4;

   // summary register bit positions
   localparam int SUM_FIFO_BIT  = 0;
   localparam int SUM_SEQ_BIT   = 1;
   localparam int SUM_LOAD_BIT  = 2;
   localparam int SUM_ALERT_BIT = 3;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      MODE_IMMEDIATE,
      MODE_MEMORY,
      MODE_FIFO,
      MODE_SEQUENCE
   } mode_type;

   // per quad-DAC group control word, mode in the low bits
   typedef struct packed {
      logic     auto_status_en;
      logic     alert_en;
      logic     load_en;
      logic     seq_en;
      mode_type mode;
   } group_ctrl_type;

   localparam int             GRP_CTRL_W      = $bits(group_ctrl_type);
   localparam group_ctrl_type GRP_CTRL_RESET  = '0;
   localparam logic [15:0]    TIMER_RESET     = 16'h0000;

   // events reported by one quad-DAC group
   typedef struct packed {
      logic       seq_request;
      logic       load_done;
      logic       status_valid;
      logic [3:0] overcurrent;
      logic       thermal_alert;
   } qdac_event_type;

   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_FIFO_EN,
      SEL_FIFO_STAT,
      SEL_GRP_STAT,
      SEL_TIMER,
      SEL_SUMMARY,
      SEL_GRP_CTRL
   } reg_sel_type;

endpackage

/* File: sim/dac_irq_sources_chk.sv */
`timescale 1ns/1ps
module dac_irq_sources_chk
   import dac_irq_pkg::*;
#(parameter int NF = 32, parameter int NG = 8, parameter int FW = 16) (
   // clock and reset
   input wire logic                    aclk,
   input wire logic                    aresetn,
   // watched ports
   input wire logic                    s_axi_bvalid,
   input wire logic [NF-1:0][FW-1:0]   fifo_fill,
   input wire logic [NF-1:0][FW-1:0]   fifo_limit,
   input wire qdac_event_type [NG-1:0] group_evt,
   input wire logic                    fifo_level_irq,
   input wire logic [NG-1:0]           sequencer_request_irq,
   input wire logic [NG-1:0]           output_load_irq,
   input wire logic [NG-1:0]           overcurrent_thermal_irq,
   input wire logic [NG-1:0]           status_read_req,
   input wire group_ctrl_type [NG-1:0] group_ctrl
);
   logic [NF-1:0] low;
   // enables are not visible here, so only the safe directions are checked
   always_comb begin
      for (int i = 0; i < NF; i++) begin
         low[i] = (fifo_fill[i] < fifo_limit[i]) || (fifo_fill[i] == '0);
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_fifo_set; $rose(fifo_level_irq) |-> |$past(low); endproperty
   property p_fifo_clr; !(|$past(low)) |-> !fifo_level_irq; endproperty
   property p_seq; group_evt[0].seq_request && group_ctrl[0].seq_en |=> sequencer_request_irq[0]; endproperty
   property p_load;
      group_evt[0].load_done && group_ctrl[0].load_en && group_ctrl[0].mode == MODE_MEMORY |=> output_load_irq[0];
   endproperty
   property p_load_mode; $rose(output_load_irq[0]) |-> $past(group_ctrl[0].mode) == MODE_MEMORY; endproperty
   property p_alert;
      group_evt[0].status_valid && group_ctrl[0].alert_en && (|group_evt[0].overcurrent || group_evt[0].thermal_alert)
         |=> overcurrent_thermal_irq[0];
   endproperty
   property p_grp1; $rose(sequencer_request_irq[1]) |-> $past(group_evt[1].seq_request); endproperty
   property p_sticky; sequencer_request_irq[0] |=> sequencer_request_irq[0] || $rose(s_axi_bvalid); endproperty
   property p_req;
      group_evt[1].seq_request && group_ctrl[1].auto_status_en && group_ctrl[1].mode == MODE_SEQUENCE
         |=> status_read_req[1];
   endproperty
   a_fifo_set: assert property (p_fifo_set) else $error("fifo flag rose without low fifo");
   a_fifo_clr: assert property (p_fifo_clr) else $error("fifo flag held with no low fifo");
   a_seq: assert property (p_seq) else $error("sequencer flag not set");
   a_load: assert property (p_load) else $error("load flag not set");
   a_load_mode: assert property (p_load_mode) else $error("load flag outside memory mode");
   a_alert: assert property (p_alert) else $error("alert flag not set");
   a_grp1: assert property (p_grp1) else $error("group 1 flag without its event");
   a_sticky: assert property (p_sticky) else $error("sequencer flag dropped alone");
   a_req: assert property (p_req) else $error("no status read request");
   c_fifo: cover property (fifo_level_irq ##1 !fifo_level_irq);
   c_seq: cover property (sequencer_request_irq[0]);
   c_req: cover property (status_read_req[0]);
endmodule // dac_irq_sources_chk

bind dac_irq_sources dac_irq_sources_chk #(.NF(NF), .NG(NG), .FW(FW)) i_chk (
   .aclk, .aresetn, .s_axi_bvalid, .fifo_fill, .fifo_limit, .group_evt, .fifo_level_irq, .sequencer_request_irq,
   .output_load_irq, .overcurrent_thermal_irq, .status_read_req, .group_ctrl);

/* File: sim/tb_dac_card_interrupt_sources.sv */
`timescale 1ns/1ps
module tb_dac_card_interrupt_sources
   import dac_irq_pkg::*;
;
   localparam int NF = 4;
   localparam int NG = 2;
   logic                    aclk = 1'b0;
   logic                    aresetn = 1'b0;
   logic                    s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic                    s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [ADDR_W-1:0]       s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [DATA_W-1:0]       s_axi_wdata = '0, s_axi_rdata;
   logic [STRB_W-1:0]       s_axi_wstrb = '0;
   logic                    s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]              s_axi_bresp, s_axi_rresp;
   logic [NF-1:0][15:0]     fifo_fill = '0, fifo_limit = '0;
   qdac_event_type [NG-1:0] group_evt = '0;
   logic                    fifo_level_irq;
   logic [NG-1:0]           sequencer_request_irq, output_load_irq, overcurrent_thermal_irq, status_read_req;
   group_ctrl_type [NG-1:0] group_ctrl;
   int                      n_mismatch = 0, num_checks = 0, cyc = 0;

   dac_irq_sources #(.NF(NF), .NG(NG)) i_dac_irq_sources (
      .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
      .fifo_fill, .fifo_limit, .group_evt, .fifo_level_irq, .sequencer_request_irq, .output_load_irq,
      .overcurrent_thermal_irq, .status_read_req, .group_ctrl);

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // every bus task is entered and left just after a rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic pa, pw, ka, kw, kb;
      logic [1:0] r;
      pa = 1'b1;
      pw = 1'b1;
      kb = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!kb) begin
         #1;
         ka = pa && s_axi_awready;
         kw = pw && s_axi_wready;
         kb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         if (ka) s_axi_awvalid <= 1'b0;
         if (kw) s_axi_wvalid <= 1'b0;
         pa = pa && !ka;
         pw = pw && !kw;
      end
      s_axi_bready <= 1'b0;
      chk(32'(r), 32'(er));
      // an edge passes, so a following write never lowers and raises bready in one step
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ka, kr;
      kr = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!kr) begin
         #1;
         ka = s_axi_arvalid && s_axi_arready;
         kr = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ka) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      // same spacing as writes, for a read straight after a read
      @(posedge aclk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      repeat (2) @(posedge aclk);
      rd(a, d, r);
      chk(32'(r), 32'(RESP_OKAY));
      chk(d, e);
   endtask
   task automatic ev(input qdac_event_type [NG-1:0] v);
      group_evt <= v;
      @(posedge aclk);
      group_evt <= '0;
      @(posedge aclk);
   endtask
   // flag and control pins, looked at once they have settled
   task automatic outs(input logic f, input logic [31:0] g, input logic [31:0] c);
      #1;
      chk(32'(fifo_level_irq), 32'(f));
      chk(32'({overcurrent_thermal_irq, output_load_irq, sequencer_request_irq}), g);
      chk(32'(group_ctrl), c);
      @(posedge aclk);
   endtask

   task automatic t_regs;
      logic [31:0] d;
      logic [1:0] r;
      rdc(OFS_FIFO_EN, 32'h0);
      rdc(OFS_GRP_CTRL, 32'h0);
      rdc(OFS_GRP_STAT, 32'h0);
      rd(8'h14, d, r);
      chk(d, 32'h0);
      chk(32'(r), 32'(RESP_SLVERR));
      wr(8'h18, 32'hFFFFFFFF, RESP_SLVERR);
      wr(OFS_TIMER, 32'h5, RESP_OKAY);
      rdc(OFS_TIMER, 32'h5);
   endtask
   task automatic t_fifo;
      for (int i = 0; i < NF; i++) begin
         fifo_fill[i] <= 16'h0064;
         fifo_limit[i] <= 16'h0032;
      end
      fifo_fill[1] <= 16'h000A;
      wr(OFS_FIFO_EN, 32'h5, RESP_OKAY);
      rdc(OFS_SUMMARY, 32'h0);
      rdc(OFS_FIFO_STAT, 32'h0);
      fifo_fill[2] <= 16'h0032;
      rdc(OFS_SUMMARY, 32'h0);
      fifo_fill[2] <= 16'h0031;
      rdc(OFS_FIFO_STAT, 32'h4);
      rdc(OFS_SUMMARY, 32'h1);
      outs(1'b1, 32'h0, 32'h0);
      fifo_fill[2] <= 16'h0064;
      fifo_fill[0] <= 16'h0000;
      fifo_limit[0] <= 16'h0000;
      rdc(OFS_FIFO_STAT, 32'h1);
      fifo_fill[0] <= 16'h0033;
      // no fifo low at all, so the checker's clear direction is exercised too
      fifo_fill[1] <= 16'h0064;
      rdc(OFS_SUMMARY, 32'h0);
      outs(1'b0, 32'h0, 32'h0);
   endtask
   task automatic t_grp;
      wr(OFS_GRP_CTRL, 32'h1D, RESP_OKAY);
      wr(OFS_GRP_CTRL + 8'h04, 32'h10, RESP_OKAY);
      ev(16'h8080);
      ev(16'h4040);
      ev(16'h2020);
      rdc(OFS_GRP_STAT, 32'h05);
      ev(16'h3021);
      rdc(OFS_GRP_STAT, 32'h35);
      outs(1'b0, 32'h35, 32'h41D);
      rdc(OFS_SUMMARY, 32'hE);
      wr(OFS_GRP_STAT, 32'h1, RESP_OKAY);
      rdc(OFS_GRP_STAT, 32'h34);
      wr(OFS_GRP_CTRL, 32'h0C, RESP_OKAY);
      wr(OFS_GRP_STAT, 32'h34, RESP_OKAY);
      ev(16'h0040);
      rdc(OFS_GRP_STAT, 32'h0);
      outs(1'b0, 32'h0, 32'h40C);
   endtask
   task automatic t_auto;
      int n0, n1;
      n0 = 0;
      n1 = 0;
      wr(OFS_GRP_CTRL, 32'h20, RESP_OKAY);
      wr(OFS_GRP_CTRL + 8'h04, 32'h27, RESP_OKAY);
      group_evt <= 16'h8000;
      @(posedge aclk);
      group_evt <= '0;
      repeat (50) begin
         #1;
         n0 += int'(status_read_req[0]);
         n1 += int'(status_read_req[1]);
         @(posedge aclk);
      end
      chk(32'(n0), 32'hA);
      chk(32'(n1), 32'h1);
      rdc(OFS_GRP_STAT, 32'h2);
      outs(1'b0, 32'h2, 32'h9E0);
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      forever #20 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         summarize;
      end
   end
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs;
      t_fifo;
      t_grp;
      t_auto;
      summarize;
   end
endmodule // tb_dac_card_interrupt_sources
